/* flash_reset_regs.vh */
`ifndef FLASH_RESET_REGS_VH
`define FLASH_RESET_REGS_VH
// =============================================================
// Timing constants, clock period in ns.
`define CLK_PERIOD_NS          100
`define CLEAR_PULSE_MIN_US     10
`define CLEAR_PULSE_MIN_CYC    ((`CLEAR_PULSE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CNT_W            8
// =============================================================
// Operation codes of the activity that a reset may interrupt.
`define OP_IDLE                3'h0
`define OP_DECODE              3'h1
`define OP_READ                3'h2
`define OP_PROGRAM             3'h3
`define OP_SMALL_ERASE         3'h4
`define OP_BLOCK_ERASE         3'h5
`define OP_CHIP_ERASE          3'h6
`define OP_STATUS_WRITE        3'h7
// =============================================================
// Power-on defaults of volatile bits.
`define LOCK_W                 8
`define LOCK_RESET_VAL         8'h00
`endif

/* pulse_width_filter.v */
`timescale 1ns/1ps
`default_nettype none
`include "flash_reset_regs.vh"
// =============================================================
// Pulse width filter: flags when the low pulse has lasted long enough.
module pulse_width_filter
(
  input  wire ref_clk_i,
  input  wire rst_i,
  input  wire clear_n_i,
  output reg  long_enough_o
);
  reg [`PULSE_CNT_W-1:0] count_reg;

  always @(posedge ref_clk_i)
  begin
    if (rst_i || clear_n_i)
    begin
      count_reg     <= {`PULSE_CNT_W{1'b0}};
      long_enough_o <= 1'b0;
    end
    else
    begin
      if (count_reg != `CLEAR_PULSE_MIN_CYC)
        count_reg <= count_reg + 8'h01;
      long_enough_o <= (count_reg >= (`CLEAR_PULSE_MIN_CYC - 1)); // [RULE_01]
    end
  end
endmodule // pulse_width_filter
`default_nettype wire

/* flash_reset_power_on.v */
// Behaviour
// RULE_01 - Reset low for at least 10 us performs a full device reset.
// RULE_02 - After reset: standby, latch, busy flag and volatile lock bits at defaults.
// RULE_03 - Reset during program or erase aborts it; data may be corrupted.
// RULE_04 - Serial data output is high impedance while reset is in progress.
// RULE_05 - Host waits 10 us after reset release before selecting the device.
// RULE_06 - Host waits 40 us decode, 35 us read, 310 us program recovery.
// RULE_07 - Host waits 12/25/100 ms after erases, 40 ms after status write.
// RULE_08 - After power-up the device is in standby with write latch cleared.
// RULE_09 - Host keeps device deselected through supply ramp and settle delay.
// RULE_10 - Host issues commands only after supply minimum plus settle delay.
// RULE_11 - Below supply clear threshold logic stays in reset and ignores commands.
// RULE_12 - Host waits 35 us after power-on reset before operating.
// RULE_13 - Unknown interrupted operation: host waits the longest recovery time.
`timescale 1ns/1ps
`default_nettype none
`include "flash_reset_regs.vh"
module flash_reset_power_on
(
  input  wire                 ref_clk_i,
  input  wire                 rst_i,
  input  wire                 supply_ok_i,
  input  wire                 clear_n_i,
  input  wire                 select_n_i,
  input  wire                 set_write_enable_i,
  input  wire                 clear_write_enable_i,
  input  wire                 op_start_i,
  input  wire [2:0]           op_code_i,
  input  wire                 op_done_i,
  input  wire                 lock_write_i,
  input  wire [`LOCK_W-1:0]   lock_data_i,
  input  wire                 data_out_i,
  input  wire                 data_out_en_i,
  output reg                  data_out_o,
  output reg                  data_out_oe_o,
  output reg                  write_enable_latch_o,
  output reg                  write_in_progress_flag_o,
  output reg  [`LOCK_W-1:0]   lock_bits_o,
  output reg  [2:0]           active_op_o,
  output reg                  op_abort_o,
  output reg  [2:0]           aborted_op_o,
  output reg                  standby_o,
  output reg                  in_reset_o,
  output reg                  command_accept_o
);
  // =============================================================
  // Qualified reset and internal logic reset.
  wire               long_enough;
  wire               hold_reset;
  wire               lock_load;
  wire [`LOCK_W-1:0] lock_next;
  wire               abort_now;
  reg                busy_op;
  reg                start_busy;
  reg                start_ok;
  reg                done_ok;
  reg  [2:0]         op_next;
  reg                wip_next;
  reg                standby_next;
  reg                wel_next;
  reg                oe_next;
  reg                accept_next;

  localparam [`LOCK_W-1:0] LOCK_DEFAULT = `LOCK_RESET_VAL;

  pulse_width_filter u_filter
  (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .clear_n_i     (clear_n_i),
    .long_enough_o (long_enough)
  );

  // Below the threshold the logic is held in reset.
  assign hold_reset = rst_i || !supply_ok_i || long_enough; // [RULE_01] [RULE_11]

  // =============================================================
  // Busy decode of the running operation.
  always @*
  begin
    case (active_op_o)
      `OP_PROGRAM:      busy_op = 1'b1;
      `OP_SMALL_ERASE:  busy_op = 1'b1;
      `OP_BLOCK_ERASE:  busy_op = 1'b1;
      `OP_CHIP_ERASE:   busy_op = 1'b1;
      `OP_STATUS_WRITE: busy_op = 1'b1;
      default:          busy_op = 1'b0;
    endcase
  end

  // =============================================================
  // Busy decode of a requested operation.
  always @*
  begin
    case (op_code_i)
      `OP_PROGRAM:      start_busy = 1'b1;
      `OP_SMALL_ERASE:  start_busy = 1'b1;
      `OP_BLOCK_ERASE:  start_busy = 1'b1;
      `OP_CHIP_ERASE:   start_busy = 1'b1;
      `OP_STATUS_WRITE: start_busy = 1'b1;
      default:          start_busy = 1'b0;
    endcase
  end

  // =============================================================
  // Operation tracking; a completion wins over a start in the same cycle.
  always @*
  begin
    start_ok     = op_start_i && (active_op_o == `OP_IDLE) && !select_n_i;
    done_ok      = op_done_i && (active_op_o != `OP_IDLE);
    op_next      = active_op_o;
    wip_next     = write_in_progress_flag_o;
    standby_next = standby_o;
    if (done_ok)
    begin
      op_next      = `OP_IDLE;
      wip_next     = 1'b0;
      standby_next = 1'b1;
    end
    else if (start_ok)
    begin
      op_next      = op_code_i;
      wip_next     = start_busy;
      standby_next = 1'b0;
    end
  end

  // =============================================================
  // Write enable latch; a set from a selected host wins over a completion or a clear request, but not over the reset hold.
  always @*
  begin
    wel_next = write_enable_latch_o;
    if (done_ok)
      wel_next = 1'b0;
    if (set_write_enable_i && !select_n_i)
      wel_next = 1'b1;
    else if (clear_write_enable_i)
      wel_next = 1'b0;
  end

  // =============================================================
  // Output enable and command acceptance.
  always @*
  begin
    oe_next     = data_out_en_i;
    accept_next = clear_n_i;
    if (select_n_i || !clear_n_i)
      oe_next = 1'b0;
  end

  // =============================================================
  // Lock bits, one load multiplexer per bit.
  assign lock_load = lock_write_i && !select_n_i;

  genvar g;
  generate
    for (g = 0; g < `LOCK_W; g = g + 1)
    begin : g_lock
      assign lock_next[g] = lock_load ? lock_data_i[g] : lock_bits_o[g];
    end
  endgenerate

  // =============================================================
  // Volatile state.
  always @(posedge ref_clk_i)
  begin
    if (hold_reset)
    begin
      write_enable_latch_o     <= 1'b0;                    // [RULE_02] [RULE_08]
      write_in_progress_flag_o <= 1'b0;                    // [RULE_02]
      lock_bits_o              <= LOCK_DEFAULT;            // [RULE_02]
      active_op_o              <= `OP_IDLE;                // [RULE_03]
      standby_o                <= 1'b1;                    // [RULE_02] [RULE_08]
      in_reset_o               <= 1'b1;
      command_accept_o         <= 1'b0;                    // [RULE_11]
    end
    else
    begin
      write_enable_latch_o     <= wel_next;
      write_in_progress_flag_o <= wip_next;
      lock_bits_o              <= lock_next;
      active_op_o              <= op_next;
      standby_o                <= standby_next;
      in_reset_o               <= 1'b0;
      command_accept_o         <= accept_next;
    end
  end

  // =============================================================
  // Serial data output; released while the reset hold lasts.
  always @(posedge ref_clk_i)
  begin
    if (hold_reset)
    begin
      data_out_o    <= 1'b0;
      data_out_oe_o <= 1'b0;                               // [RULE_04]
    end
    else
    begin
      data_out_o    <= data_out_i;
      data_out_oe_o <= oe_next;
    end
  end

  // =============================================================
  // Abort report, kept outside the reset hold so it survives it.
  assign abort_now = long_enough && !in_reset_o && (active_op_o != `OP_IDLE);

  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      op_abort_o   <= 1'b0;
      aborted_op_o <= `OP_IDLE;
    end
    else if (abort_now)
    begin
      op_abort_o   <= busy_op;                             // [RULE_03]
      aborted_op_o <= active_op_o;
    end
    else
    begin
      op_abort_o <= 1'b0;
    end
  end
endmodule // flash_reset_power_on
`default_nettype wire

/* flash_reset_power_on_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module frpo_check
(
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       supply_ok_i,
  input wire logic       clear_n_i,
  input wire logic       data_out_oe_o,
  input wire logic       write_enable_latch_o,
  input wire logic       write_in_progress_flag_o,
  input wire logic [7:0] lock_bits_o,
  input wire logic [2:0] active_op_o,
  input wire logic       op_abort_o,
  input wire logic       standby_o,
  input wire logic       in_reset_o,
  input wire logic       command_accept_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] low_reg;
  always @(posedge ref_clk_i) low_reg <= (rst_i || clear_n_i) ? 8'h00 : low_reg + {7'h0, low_reg != 8'hff};
  sequence abort_pulse; op_abort_o ##1 !op_abort_o; endsequence
  a_long_low_resets: assert property (low_reg > 8'h68 |-> in_reset_o) else $error("long low pulse ignored");
  a_reset_defaults: assert property (in_reset_o |-> !write_enable_latch_o && !write_in_progress_flag_o
    && lock_bits_o == 8'h00 && standby_o && !command_accept_o) else $error("volatile state not cleared");
  a_busy_abort: assert property ($rose(in_reset_o) && $past(supply_ok_i) && $past(active_op_o) >= 3'h3 |-> abort_pulse)
    else $error("busy operation not aborted");
  a_output_released: assert property (in_reset_o |-> !data_out_oe_o) else $error("output driven in reset");
  a_power_up_state: assert property ($fell(rst_i) |-> standby_o && !write_enable_latch_o) else $error("bad power-up");
  a_supply_hold: assert property (!supply_ok_i [*3] |-> in_reset_o && !command_accept_o) else $error("low supply");
endmodule // frpo_check
bind flash_reset_power_on frpo_check u_check (.*);
`default_nettype wire

/* flash_host.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_host
(
  input  wire logic ref_clk_i,
  output var  logic clear_n_o,
  output var  logic select_n_o
);
  initial
  begin
    clear_n_o  = 1'b1;
    select_n_o = 1'b1;
  end
  // Recovery in 100 ns cycles after a reset that cut the given operation.
  function automatic int recovery_cycles(input int op);
    case (op)
      0: return 100;
      1: return 400;
      2: return 350;
      3: return 3100;
      4: return 120000;
      5: return 250000;
      6: return 1000000;
      7: return 400000;
      default: return 1000000;
    endcase
  endfunction
  task automatic hold_clear(input int n);
    @(posedge ref_clk_i) #10 clear_n_o <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
    #10;
  endtask
  task automatic release_clear(input int cyc);
    #10 clear_n_o <= 1'b1;
    repeat (cyc) @(posedge ref_clk_i);
    #10;
  endtask
  task automatic select(input logic s);
    @(posedge ref_clk_i) #10 select_n_o <= s;
  endtask
endmodule // flash_host
`default_nettype wire

/* flash_reset_power_on_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_reset_power_on_tb;
  logic       ref_clk_i = 1'b0, rst_i = 1'b1, supply_ok_i = 1'b1, clear_n_i, select_n_i, data_out_i = 1'b0;
  logic       set_write_enable_i = 1'b0, clear_write_enable_i = 1'b0, op_start_i = 1'b0, op_done_i = 1'b0;
  logic       lock_write_i = 1'b0, data_out_en_i = 1'b1;
  logic [2:0] op_code_i = 3'h0, code;
  logic       din_seen;
  logic [7:0] lock_data_i = 8'h00;
  wire        data_out_o, data_out_oe_o, write_enable_latch_o, write_in_progress_flag_o;
  wire        op_abort_o, standby_o, in_reset_o, command_accept_o;
  wire  [7:0] lock_bits_o;
  wire  [2:0] active_op_o, aborted_op_o;
  logic [2:0] exp_q[$];
  int         bad_count = 0, compares = 0, cyc = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) #10 data_out_i <= 1'($urandom());
  always @(posedge ref_clk_i) din_seen <= data_out_i;
  flash_host u_host (.ref_clk_i(ref_clk_i), .clear_n_o(clear_n_i), .select_n_o(select_n_i));
  flash_reset_power_on u_dut (.*);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (e !== g)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge ref_clk_i)
  begin
    cyc++;
    if (op_abort_o === 1'b1)
      chk("aborted op", exp_q.size() ? {5'h0, exp_q.pop_front()} : 8'hff, {5'h0, aborted_op_o});
    if (in_reset_o === 1'b0)
      chk("data out", {7'h0, din_seen}, {7'h0, data_out_o});
    if (cyc > 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(32'h0587d141));
    repeat (5) @(posedge ref_clk_i);
    #10 rst_i <= 1'b0;
    @(posedge ref_clk_i) #10 chk("standby", 8'h1, {7'h0, standby_o});
    chk("power latch", 8'h0, {7'h0, write_enable_latch_o});
    repeat (350) @(posedge ref_clk_i);
    #10;
    // The last pass cuts one random erase or status write operation; no command follows it, so its long recovery never gates the run.
    for (int op = 0; op < 5; op++)
    begin
      code = (op < 4) ? 3'(op) : 3'(4 + ($urandom() % 4));
      lock_data_i = 8'($urandom());
      u_host.select(1'b0);
      @(posedge ref_clk_i) #10 {set_write_enable_i, lock_write_i, op_start_i, op_code_i} <= {3'b111, code};
      @(posedge ref_clk_i) #10 {set_write_enable_i, lock_write_i, op_start_i} <= 3'b000;
      chk("lock", lock_data_i, lock_bits_o);
      chk("busy", {7'h0, code > 3'h2}, {7'h0, write_in_progress_flag_o});
      chk("op", {5'h0, code}, {5'h0, active_op_o});
      if (code > 3'h2)
        exp_q.push_back(code);
      u_host.hold_clear(op == 0 ? 95 : 105);
      chk("in reset", {7'h0, op != 0}, {7'h0, in_reset_o});
      chk("latch", {7'h0, op == 0}, {7'h0, write_enable_latch_o});
      chk("lock reset", op == 0 ? lock_data_i : 8'h00, lock_bits_o);
      chk("reset standby", {7'h0, op != 0}, {7'h0, standby_o});
      chk("drive", 8'h0, {7'h0, data_out_oe_o});
      u_host.select(1'b1);
      u_host.release_clear(op < 4 ? u_host.recovery_cycles(code) : 100);
      chk("accept", 8'h1, {7'h0, command_accept_o});
      $display("test op %0d done", code);
    end
    #10 supply_ok_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #10 chk("supply hold", 8'h1, {7'h0, in_reset_o});
    supply_ok_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    chk("pending aborts", 8'h0, 8'(exp_q.size()));
    complete_run();
  end
endmodule // flash_reset_power_on_tb
`default_nettype wire
